//--- bench/mbcmd_master_model.sv
// Serial-line master model: sends request frames, collects responses.
// Assumes the handler's decoded-byte receive and transmit ports.
`default_nettype none
module mbcmd_master_model (
   input  wire logic       clk_in,
   input  wire logic       ascii_in,
   input  wire logic       slow_in,
   input  wire logic       tx_vld_in,
   input  wire logic [7:0] tx_byte_in,
   output var  logic       rx_sof_out = 1'b0,
   output var  logic       rx_vld_out = 1'b0,
   output var  logic [7:0] rx_byte_out = 8'h00,
   output var  logic       rx_eof_out = 1'b0,
   output var  logic       tx_rdy_out = 1'b0
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] rsp[$];
   // Response capture; slow mode stalls at random
   always @(posedge clk_in) begin
      if (tx_vld_in && tx_rdy_out)
         rsp.push_back(tx_byte_in);
      tx_rdy_out <= slow_in ? 1'($urandom_range(1)) : 1'b1;
   end
   // One frame in the shared mode, check code appended
   task automatic send(input logic [7:0] f[$], input logic bad);
      logic [15:0] crc;
      logic [7:0]  lrc;
      crc = 16'hffff;
      lrc = 8'h00;
      foreach (f[i]) begin
         lrc = lrc - f[i];
         crc = crc ^ {8'h00, f[i]};
         repeat (8) crc = crc[0] ? (crc >> 1) ^ 16'ha001 : crc >> 1;
      end
      if (ascii_in)
         f.push_back(lrc ^ {7'h00, bad});
      else begin
         f.push_back(crc[7:0] ^ {7'h00, bad});
         f.push_back(crc[15:8]);
      end
      rx_sof_out <= 1'b1;
      @(posedge clk_in);
      rx_sof_out <= 1'b0;
      foreach (f[i]) begin
         rx_vld_out  <= 1'b1;
         rx_byte_out <= f[i];
         @(posedge clk_in);
         rx_vld_out  <= 1'b0;
         rx_byte_out <= ~f[i]; // Idle line shows no stale byte
         @(posedge clk_in);
      end
      rx_eof_out <= 1'b1;
      @(posedge clk_in);
      rx_eof_out <= 1'b0;
   endtask
endmodule // mbcmd_master_model
`default_nettype wire

//--- bench/mbcmd_top_sva.sv
// Port checker for the slave command handler.
// Assumes one clock domain and an active-high asynchronous reset.
`default_nettype none
module mbcmd_top_sva #(
   parameter int AW = 6
) (
   input wire logic        clk_in,
   input wire logic        sys_rst_in,
   input wire logic        rx_vld_in,
   input wire logic [15:0] reg_base_in,
   input wire logic        tx_rdy_in,
   input wire logic        tx_vld_out,
   input wire logic [7:0]  tx_byte_out,
   input wire logic        tx_last_out,
   input wire logic        reg_we_out,
   input wire logic [15:0] reg_addr_out,
   input wire logic        busy_out
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   // Register writes: single strobes, consecutive, inside the window
   a_we_single: assert property (reg_we_out |=> !reg_we_out)
      else $error("write strobe longer than one cycle");
   a_we_consec: assert property (reg_we_out && $past(reg_we_out, 2) |->
      reg_addr_out == $past(reg_addr_out, 2) + 16'h1)
      else $error("write addresses not consecutive");
   a_we_window: assert property (reg_we_out |-> reg_addr_out >= reg_base_in
      && {1'b0, reg_addr_out} < {1'b0, reg_base_in} + (17'h1 << AW))
      else $error("write outside the register window");
   // Response bytes: held while stalled, only after the frame
   a_tx_hold: assert property (tx_vld_out && !tx_rdy_in |=> tx_vld_out
      && $stable(tx_byte_out) && $stable(tx_last_out))
      else $error("response byte changed while stalled");
   a_tx_end: assert property (tx_vld_out && tx_rdy_in && tx_last_out
      |=> !tx_vld_out)
      else $error("response continues after last byte");
   a_rx_quiet: assert property (rx_vld_in |-> !tx_vld_out)
      else $error("response sent during reception");
   a_out_busy: assert property ((tx_vld_out || reg_we_out) |-> busy_out)
      else $error("activity while not busy");
   a_busy_ends: assert property ($rose(busy_out) |-> ##[1:1000] !busy_out)
      else $error("frame handling never ends");
endmodule // mbcmd_top_sva
bind mbcmd_top mbcmd_top_sva #(.AW(AW)) mbcmd_top_sva_inst (
   .clk_in       (clk_in),
   .sys_rst_in   (sys_rst_in),
   .rx_vld_in    (rx_vld_in),
   .reg_base_in  (reg_base_in),
   .tx_rdy_in    (tx_rdy_in),
   .tx_vld_out   (tx_vld_out),
   .tx_byte_out  (tx_byte_out),
   .tx_last_out  (tx_last_out),
   .reg_we_out   (reg_we_out),
   .reg_addr_out (reg_addr_out),
   .busy_out     (busy_out)
);
`default_nettype wire

//--- bench/tb.sv
// Self-checking bench for the slave command handler.
// Assumes the master model and the bound checker are compiled first.
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int AW = 6;
   logic clk_in = 1'b0, sys_rst_in = 1'b1, ascii_mode_in = 1'b0, slow = 1'b0;
   logic rx_len_err_in = 1'b0, wr_fail_in = 1'b0, rx_sof, rx_vld, rx_eof;
   logic tx_rdy, tx_vld, tx_last, reg_we_out, busy_out;
   logic [7:0] station_addr_in = 8'h01, rx_byte, tx_byte, own, exp[$];
   logic [15:0] reg_base_in = 16'h0000, reg_addr_out, reg_data_out;
   logic [15:0] wa[$], wd[$], ga[$], gd[$];
   int checked = 0, miscompares = 0, tn = 0, nchk = 99;
   mbcmd_top #(.AW(AW)) mbcmd_top_inst (.clk_in(clk_in),
      .sys_rst_in(sys_rst_in), .ascii_mode_in(ascii_mode_in),
      .station_addr_in(station_addr_in), .rx_sof_in(rx_sof),
      .rx_vld_in(rx_vld), .rx_byte_in(rx_byte), .rx_eof_in(rx_eof),
      .rx_len_err_in(rx_len_err_in), .reg_base_in(reg_base_in),
      .wr_fail_in(wr_fail_in), .tx_rdy_in(tx_rdy), .tx_vld_out(tx_vld),
      .tx_byte_out(tx_byte), .tx_last_out(tx_last), .reg_we_out(reg_we_out),
      .reg_addr_out(reg_addr_out), .reg_data_out(reg_data_out),
      .busy_out(busy_out));
   mbcmd_master_model mbcmd_master_model_inst (.clk_in(clk_in),
      .ascii_in(ascii_mode_in), .slow_in(slow), .tx_vld_in(tx_vld),
      .tx_byte_in(tx_byte), .rx_sof_out(rx_sof), .rx_vld_out(rx_vld),
      .rx_byte_out(rx_byte), .rx_eof_out(rx_eof), .tx_rdy_out(tx_rdy));
   // Clock and write capture
   always #12.5 clk_in = ~clk_in;
   always @(posedge clk_in) begin
      if (reg_we_out === 1'b1) begin
         ga.push_back(reg_addr_out);
         gd.push_back(reg_data_out);
      end
   end
   task automatic chk_word(input logic [15:0] got, input logic [15:0] ex);
      checked++;
      if (got !== ex) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, ex);
      end
   endtask
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] ex);
      chk_word({8'h00, got}, {8'h00, ex});
   endtask
   task automatic stop_test();
      $display("comparisons %0d, mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Send, wait for the handler to go idle, compare with the model
   task automatic run(input logic [7:0] f[$], input logic bad);
      int n;
      ga.delete();
      mbcmd_master_model_inst.rsp.delete();
      mbcmd_master_model_inst.send(f, bad);
      n = 0;
      repeat (2) @(negedge clk_in);
      while (busy_out !== 1'b0 && n < 2000) begin
         @(negedge clk_in);
         n++;
      end
      if (n == 2000)
         miscompares++;
      @(posedge clk_in);
      chk_word(16'(mbcmd_master_model_inst.rsp.size()), 16'(exp.size()));
      foreach (exp[i])
         if (i < nchk && i < mbcmd_master_model_inst.rsp.size())
            chk_byte(mbcmd_master_model_inst.rsp[i], exp[i]);
      chk_word(16'(ga.size()), 16'(wa.size()));
      foreach (wa[i])
         if (i < ga.size()) begin
            chk_word(ga[i], wa[i]);
            chk_word(gd[i], wd[i]);
         end
      tn++;
      $display("test %0d done", tn);
      exp.delete();
      wa.delete();
      wd.delete();
      gd.delete();
      nchk = 99;
   endtask
   // Register write request and its expected outcome
   task automatic wr(input logic [7:0] sa, input logic [15:0] st, cnt,
                     input logic [7:0] bc, input logic bad);
      logic [7:0]  f[$], ec;
      logic [15:0] w;
      logic        ok;
      ec = (cnt == 0 || cnt > 50 || 16'(bc) != 2 * cnt) ? 8'h03 :
           (st < reg_base_in || 17'(st) + 17'(cnt) > 17'(reg_base_in) +
           (17'h1 << AW)) ? 8'h02 : wr_fail_in ? 8'h04 : 8'h00;
      ok = !bad && !rx_len_err_in && (sa == own || sa == 8'h00);
      f = {sa, 8'h10, st[15:8], st[7:0], cnt[15:8], cnt[7:0], bc};
      for (int i = 0; i < bc / 2; i++) begin
         w = 16'($urandom);
         f.push_back(w[15:8]);
         f.push_back(w[7:0]);
         if (ok && ec == 8'h00) begin
            wa.push_back(st + 16'(i));
            wd.push_back(w);
         end
      end
      if (ok && sa != 8'h00)
         exp = (ec != 8'h00) ? {sa, 8'h90, ec} : f[0:5];
      run(f, bad);
   endtask
   // Diagnostics request and its expected outcome
   task automatic dg(input logic [7:0] sa, input logic [15:0] sub, dat);
      logic [7:0] f[$];
      f = {sa, 8'h08, sub[15:8], sub[7:0], dat[15:8], dat[7:0]};
      if (sa == own) begin
         if (sub < 16'h000a || sub > 16'h0012)
            exp = {sa, 8'h88, 8'h01};
         else if (dat != 16'h0000)
            exp = {sa, 8'h88, 8'h03};
         else begin
            exp = {f[0:3], 8'h00, 8'h00};
            nchk = (sub == 16'h000b) ? 4 : 6;
         end
      end
      run(f, 1'b0);
   endtask
   task automatic setin(input logic le, wf, am);
      rx_len_err_in <= le;
      wr_fail_in    <= wf;
      ascii_mode_in <= am;
      slow          <= am;
      @(posedge clk_in);
   endtask
   // Watchdog
   initial begin
      #(25ns * 60000);
      miscompares++;
      stop_test();
   end
   // Main sequence
   initial begin
      void'($urandom(135));
      own = 8'(1 + $urandom_range(246));
      repeat (20) @(posedge clk_in);
      sys_rst_in      <= 1'b0;
      station_addr_in <= own;
      reg_base_in     <= 16'(1 + $urandom_range(200));
      @(posedge clk_in);
      wr(own, reg_base_in + 16'd7, 16'd3, 8'd6, 1'b0);
      wr(own, reg_base_in, 16'd50, 8'd100, 1'b0);
      wr(own, reg_base_in, 16'd51, 8'd102, 1'b0);
      wr(own, reg_base_in, 16'd3, 8'd4, 1'b0);
      wr(own, reg_base_in + 16'd62, 16'd3, 8'd6, 1'b0);
      wr(own, reg_base_in - 16'd1, 16'd1, 8'd2, 1'b0);
      wr(8'h00, reg_base_in + 16'd20, 16'd2, 8'd4, 1'b0);
      wr(own, reg_base_in, 16'd2, 8'd4, 1'b1);
      wr(own ^ 8'h40, reg_base_in, 16'd2, 8'd4, 1'b0);
      setin(1'b1, 1'b0, 1'b0);
      wr(own, reg_base_in, 16'd2, 8'd4, 1'b0);
      setin(1'b0, 1'b1, 1'b0);
      wr(own, reg_base_in, 16'd2, 8'd4, 1'b0);
      setin(1'b0, 1'b0, 1'b0);
      exp = {own, 8'h83, 8'h01};
      run({own, 8'h03, 8'h00, 8'h01, 8'h00, 8'h01}, 1'b0);
      dg(own, 16'h000a, 16'h0000);
      for (int s = 11; s <= 19; s++)
         dg(own, 16'(s), 16'h0000);
      dg(own, 16'h0009, 16'h0000);
      dg(own, 16'h000c, 16'h0001);
      dg(8'h00, 16'h000a, 16'h0000);
      setin(1'b0, 1'b0, 1'b1);
      wr(own, reg_base_in + 16'd40, 16'd4, 8'd8, 1'b0);
      wr(own, reg_base_in, 16'd2, 8'd4, 1'b1);
      dg(own, 16'h000a, 16'h0000);
      stop_test();
   end
endmodule // tb
`default_nettype wire

//--- include/mbcmd_defs.vh
// Constants for the serial-line slave command handler.
// Assumes a byte-level receiver and transmitter outside this block.
//
// Operation
// [RQ1] Function 10H writes consecutive 16-bit registers: start, count, data.
// [RQ2] Broadcast register write is applied but never answered.
// [RQ3] Successful register write answers with echoed request fields.
// [RQ4] Addresses, counts and values travel high byte first, then low byte.
// [RQ5] In ASCII each byte is sent as two hex characters.
// [RQ6] Keep per-state counters of received frames for line quality checks.
// [RQ7] Function 08H carries sub-function and data; 0A..12H only, data zero.
// [RQ8] Broadcast diagnostics is neither acted on nor answered.
// [RQ9] Diagnostics answer echoes function, sub-function, then counter.
// [RQ10] Sub-function 000AH clears counters and echoes the request data. Slot 0 is bumped instead of cleared, since its increment wins.
// [RQ11] RTU frames carry a CRC made by sender, checked by receiver.
// [RQ12] ASCII frames carry an LRC made by sender, checked by receiver.
// [RQ13] A frame failing its check changes no register and no output.
// [RQ14] Errors answer with an exception, except check and length errors.
// [RQ15] Exception function is request function plus 128, then one code byte.
// [RQ16] Unsupported function code answers exception 01.
// [RQ17] Unsupported data address answers exception 02.
// [RQ18] Illegal written value answers exception 03.
// [RQ19] Failed unrecoverable write answers exception 04.
// [RQ20] At most 50 registers per command; more answers an exception.
// [RQ21] All stations share mode, baud and parity, each with unique address.
// [RQ22] Byte count must equal twice register count, else exception.
`ifndef MBCMD_DEFS_VH
`define MBCMD_DEFS_VH
`define MB_FN_WRMULTI   8'h10
`define MB_FN_DIAG      8'h08
`define MB_EXC_FLAG     8'h80
`define MB_EXC_FUNC     8'h01
`define MB_EXC_ADDR     8'h02
`define MB_EXC_VALUE    8'h03
`define MB_EXC_FAIL     8'h04
`define MB_BCAST_ADDR   8'h00
`define MB_MAX_REGS     16'd50
`define MB_SUB_CLEAR    16'h000a
`define MB_SUB_LAST     16'h0012
`define MB_CRC_INIT     16'hffff
`define MB_CRC_POLY     16'ha001
`define MB_NCNT         9
`endif

//--- verilog/mbcmd_crc.v
// CRC-16 and LRC accumulator, one byte per strobe.
// Assumes bytes arrive in wire order, cleared at frame start.
`default_nettype none
`include "mbcmd_defs.vh"
module mbcmd_crc (
   input  wire        clk_in,
   input  wire        sys_rst_in,
   input  wire        clr_in,
   input  wire        byte_vld_in,
   input  wire [7:0]  byte_in,
   output reg  [15:0] crc_out,
   output reg  [7:0]  lrc_out
);
   reg [15:0] next_crc;
   integer    i;

   // Bitwise reflected CRC over one byte
   always @* begin
      next_crc = crc_out ^ {8'h00, byte_in};
      for (i = 0; i < 8; i = i + 1) begin
         if (next_crc[0])
            next_crc = (next_crc >> 1) ^ `MB_CRC_POLY;
         else
            next_crc = next_crc >> 1;
      end
   end

   // Running sums; LRC kept as plain sum, negated by user
   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         crc_out <= `MB_CRC_INIT;
         lrc_out <= 8'h00;
      end else if (clr_in) begin
         crc_out <= `MB_CRC_INIT;
         lrc_out <= 8'h00;
      end else if (byte_vld_in) begin
         crc_out <= next_crc;               // see [RQ11]
         lrc_out <= lrc_out + byte_in;      // see [RQ12]
      end
   end
endmodule // mbcmd_crc
`default_nettype wire

//--- verilog/mbcmd_mem.v
// Small register-data store, one 16-bit word per entry.
// Assumes one write and one read per cycle; read data registered.
`default_nettype none
module mbcmd_mem #(
   parameter AW = 6
) (
   input  wire          clk_in,
   input  wire          we_in,
   input  wire [AW-1:0] waddr_in,
   input  wire [15:0]   wdata_in,
   input  wire [AW-1:0] raddr_in,
   output reg  [15:0]   rdata_out
);
   reg [15:0] mem [0:(1<<AW)-1];

   // Write port and registered read port
   always @(posedge clk_in) begin
      if (we_in)
         mem[waddr_in] <= wdata_in;
      rdata_out <= mem[raddr_in];
   end
endmodule // mbcmd_mem
`default_nettype wire

//--- verilog/mbcmd_top.v
// Slave command handler for write-multiple and diagnostics commands.
// Assumes a receiver giving frame bytes (address..check) with start and
// end strobes, and a transmitter that takes one byte per ready cycle.
`default_nettype none
`include "mbcmd_defs.vh"
module mbcmd_top #(
   parameter AW = 6
) (
   input  wire          clk_in,
   input  wire          sys_rst_in,
   input  wire          ascii_mode_in,
   input  wire [7:0]    station_addr_in,
   input  wire          rx_sof_in,
   input  wire          rx_vld_in,
   input  wire [7:0]    rx_byte_in,
   input  wire          rx_eof_in,
   input  wire          rx_len_err_in,
   input  wire [15:0]   reg_base_in,
   input  wire          wr_fail_in,
   input  wire          tx_rdy_in,
   output reg           tx_vld_out,
   output reg  [7:0]    tx_byte_out,
   output reg           tx_last_out,
   output reg           reg_we_out,
   output reg  [15:0]   reg_addr_out,
   output reg  [15:0]   reg_data_out,
   output reg           busy_out
);
   // Sequencer state codes
   localparam S_IDLE = 3'd0;
   localparam S_RX   = 3'd1;
   localparam S_EVAL = 3'd2;
   localparam S_APPLY= 3'd3;
   localparam S_RD   = 3'd4;
   localparam S_TX   = 3'd5;
   localparam S_DROP = 3'd6;

   reg [2:0]    state;
   reg [7:0]    hdr [0:6];     // addr, fn, a_hi, a_lo, n_hi, n_lo, bc
   reg [7:0]    nbytes;
   reg [7:0]    last1;
   reg [7:0]    last2;
   reg [15:0]   crc_prev;
   reg [7:0]    lrc_prev;
   reg [AW-1:0] wptr;
   reg          wr_hi;
   reg [7:0]    hi_byte;
   reg          store_we;
   reg [15:0]   store_wd;
   reg [AW-1:0] apply_idx;
   reg [7:0]    tx_buf [0:7];
   reg [3:0]    tx_len;
   reg [3:0]    tx_idx;
   reg [15:0]   cnt [0:`MB_NCNT-1];
   reg          cnt_clr;
   reg [3:0]    cnt_inc;
   reg          cnt_inc_en;
   reg [15:0]   crc_hold;

   wire [15:0] crc_now;
   wire [7:0]  lrc_now;
   wire [15:0] mem_rd;
   wire [15:0] start_a  = {hdr[2], hdr[3]};   // see [RQ4]
   wire [15:0] regcnt   = {hdr[4], hdr[5]};   // see [RQ4]
   wire [15:0] diag_sub = {hdr[2], hdr[3]};
   wire [15:0] diag_dat = {hdr[4], hdr[5]};
   wire        bcast    = (hdr[0] == `MB_BCAST_ADDR);
   wire        mine     = (hdr[0] == station_addr_in) || bcast;
   // RTU check low byte first; ASCII LRC is two's complement of sum
   wire        crc_ok   = ({last2, last1} == crc_prev);
   wire [7:0]  lrc_neg  = 8'h00 - lrc_prev;
   wire        lrc_ok   = (last2 == lrc_neg);
   wire        chk_ok   = ascii_mode_in ? lrc_ok : crc_ok;   // see [RQ11] see [RQ12]

   // Byte accumulator for the check code
   mbcmd_crc u_crc (
      .clk_in      (clk_in),
      .sys_rst_in  (sys_rst_in),
      .clr_in      (rx_sof_in),
      .byte_vld_in (rx_vld_in),
      .byte_in     (rx_byte_in),
      .crc_out     (crc_now),
      .lrc_out     (lrc_now)
   );

   // Staging store so a bad frame never reaches the register outputs
   mbcmd_mem #(.AW(AW)) u_mem (
      .clk_in    (clk_in),
      .we_in     (store_we),
      .waddr_in  (wptr),
      .wdata_in  (store_wd),
      .raddr_in  (apply_idx),
      .rdata_out (mem_rd)
   );

   // Counter bank: cleared or bumped per received frame class
   genvar g;
   generate
      for (g = 0; g < `MB_NCNT; g = g + 1) begin : g_cnt
         always @(posedge clk_in or posedge sys_rst_in) begin
            if (sys_rst_in)
               cnt[g] <= 16'h0000;
            else if (cnt_inc_en && cnt_inc == g)
               cnt[g] <= cnt[g] + 16'h0001;   // see [RQ6]
            else if (cnt_clr)
               cnt[g] <= 16'h0000;            // see [RQ10]
         end
      end
   endgenerate

   // Counter slots: 0 bus msgs, 1 check errs, 2 exceptions, 3 slave msgs,
   // 4 no response, 5..7 spare reads, 8 never read, slot chosen by sub-function
   wire [3:0]  sub_slot = diag_sub[3:0] - 4'hb;
   wire [15:0] cnt_sel  = cnt[(sub_slot < `MB_NCNT) ? sub_slot : 4'd0];

   // Header capture and check-code history while receiving
   integer k;
   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         nbytes   <= 8'h00;
         last1    <= 8'h00;
         last2    <= 8'h00;
         crc_prev <= `MB_CRC_INIT;
         lrc_prev <= 8'h00;
         wptr     <= {AW{1'b0}};
         wr_hi    <= 1'b1;
         hi_byte  <= 8'h00;
         store_we <= 1'b0;
         store_wd <= 16'h0000;
         for (k = 0; k < 7; k = k + 1)
            hdr[k] <= 8'h00;
      end else begin
         store_we <= 1'b0;
         if (rx_sof_in) begin
            nbytes <= 8'h00;
            wptr   <= {AW{1'b0}};
            wr_hi  <= 1'b1;
         end else if (rx_vld_in && state == S_RX) begin
            nbytes <= (nbytes == 8'hff) ? nbytes : nbytes + 8'h01;
            if (nbytes < 8'd7)
               hdr[nbytes[2:0]] <= rx_byte_in;   // see [RQ1]
            // History lags: crc_prev excludes last two bytes (RTU)
            last1    <= last2;
            last2    <= rx_byte_in;
            crc_prev <= (nbytes >= 8'd1) ? crc_hold : `MB_CRC_INIT;
            lrc_prev <= lrc_now;                 // see [RQ12]
            // Stage data bytes high first; the check bytes land past count
            if (nbytes >= 8'd7) begin
               wr_hi <= ~wr_hi;
               if (wr_hi)
                  hi_byte <= rx_byte_in;
               else begin
                  store_we <= 1'b1;
                  store_wd <= {hi_byte, rx_byte_in};  // see [RQ4]
               end
            end
         end
         if (store_we)
            wptr <= wptr + {{(AW-1){1'b0}}, 1'b1};
      end
   end

   // CRC value one byte behind the accumulator
   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in)
         crc_hold <= `MB_CRC_INIT;
      else if (rx_sof_in)
         crc_hold <= `MB_CRC_INIT;
      else if (rx_vld_in)
         crc_hold <= crc_now;
   end

   integer j;

   // Main sequencer: evaluate, apply, answer
   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state        <= S_IDLE;
         tx_len       <= 4'd0;
         tx_idx       <= 4'd0;
         apply_idx    <= {AW{1'b0}};
         reg_we_out   <= 1'b0;
         reg_addr_out <= 16'h0000;
         reg_data_out <= 16'h0000;
         tx_vld_out   <= 1'b0;
         tx_byte_out  <= 8'h00;
         tx_last_out  <= 1'b0;
         busy_out     <= 1'b0;
         cnt_clr      <= 1'b0;
         cnt_inc      <= 4'd0;
         cnt_inc_en   <= 1'b0;
         for (j = 0; j < 8; j = j + 1)
            tx_buf[j] <= 8'h00;
      end else begin
         reg_we_out <= 1'b0;
         cnt_clr    <= 1'b0;
         cnt_inc_en <= 1'b0;
         case (state)
            S_IDLE: begin
               busy_out <= 1'b0;
               if (rx_sof_in) begin
                  state    <= S_RX;
                  busy_out <= 1'b1;
               end
            end
            S_RX: begin
               if (rx_eof_in)
                  state <= S_EVAL;
            end
            S_EVAL: begin
               tx_buf[0] <= station_addr_in;
               // Flagged by default; normal answers restore the code
               tx_buf[1] <= hdr[1] | `MB_EXC_FLAG;   // see [RQ15]
               tx_idx    <= 4'd0;
               state     <= S_DROP;
               cnt_inc_en <= 1'b1;
               cnt_inc    <= 4'd0;
               if (rx_len_err_in) begin
                  cnt_inc <= 4'd4;                  // see [RQ14]
               end else if (!chk_ok) begin
                  cnt_inc <= 4'd1;                  // see [RQ13]
               end else if (!mine) begin
                  cnt_inc <= 4'd0;
               end else if (hdr[1] == `MB_FN_WRMULTI) begin
                  cnt_inc <= 4'd3;
                  if (regcnt == 16'h0000 || regcnt > `MB_MAX_REGS ||
                      {8'h00, hdr[6]} != {regcnt[14:0], 1'b0}) begin
                     tx_buf[2] <= `MB_EXC_VALUE;    // see [RQ20] see [RQ22]
                     tx_len    <= 4'd3;
                     state     <= bcast ? S_DROP : S_TX;
                  end else if ({1'b0, start_a} + {1'b0, regcnt} >
                               {1'b0, reg_base_in} + 17'd64) begin
                     tx_buf[2] <= `MB_EXC_ADDR;     // see [RQ17]
                     tx_len    <= 4'd3;
                     state     <= bcast ? S_DROP : S_TX;
                  end else if (start_a < reg_base_in) begin
                     tx_buf[2] <= `MB_EXC_ADDR;     // see [RQ17]
                     tx_len    <= 4'd3;
                     state     <= bcast ? S_DROP : S_TX;
                  end else begin
                     apply_idx <= {AW{1'b0}};
                     state     <= S_RD;             // see [RQ2]
                  end
               end else if (hdr[1] == `MB_FN_DIAG) begin
                  if (bcast) begin
                     state <= S_DROP;               // see [RQ8]
                  end else if (diag_sub < `MB_SUB_CLEAR ||
                               diag_sub > `MB_SUB_LAST) begin
                     tx_buf[2] <= `MB_EXC_FUNC;     // see [RQ7]
                     tx_len    <= 4'd3;
                     state     <= S_TX;
                  end else if (diag_dat != 16'h0000) begin
                     tx_buf[2] <= `MB_EXC_VALUE;    // see [RQ7] see [RQ18]
                     tx_len    <= 4'd3;
                     state     <= S_TX;
                  end else begin
                     tx_buf[1] <= hdr[1];
                     tx_buf[2] <= hdr[2];           // see [RQ9]
                     tx_buf[3] <= hdr[3];
                     tx_buf[4] <= (diag_sub == `MB_SUB_CLEAR) ?
                                  hdr[4] : cnt_sel[15:8];
                     tx_buf[5] <= (diag_sub == `MB_SUB_CLEAR) ?
                                  hdr[5] : cnt_sel[7:0];
                     cnt_clr   <= (diag_sub == `MB_SUB_CLEAR);  // see [RQ10]
                     tx_len    <= 4'd6;
                     state     <= S_TX;
                  end
               end else begin
                  tx_buf[2] <= `MB_EXC_FUNC;        // see [RQ16]
                  tx_len    <= 4'd3;
                  state     <= bcast ? S_DROP : S_TX;
               end
            end
            S_RD: begin
               // Two cycles per word (S_RD then S_APPLY): address out, memory read lags one
               if (wr_fail_in) begin
                  tx_buf[1] <= hdr[1] | `MB_EXC_FLAG;   // see [RQ15]
                  tx_buf[2] <= `MB_EXC_FAIL;            // see [RQ19]
                  tx_len    <= 4'd3;
                  state     <= bcast ? S_DROP : S_TX;
               end else begin
                  state <= S_APPLY;
               end
            end
            S_APPLY: begin
               reg_we_out   <= 1'b1;
               reg_addr_out <= start_a + {{(16-AW){1'b0}}, apply_idx};
               reg_data_out <= mem_rd;
               if ({{(16-AW){1'b0}}, apply_idx} + 16'h0001 == regcnt) begin
                  tx_buf[1] <= hdr[1];
                  tx_buf[2] <= hdr[2];              // see [RQ3]
                  tx_buf[3] <= hdr[3];
                  tx_buf[4] <= hdr[4];
                  tx_buf[5] <= hdr[5];
                  tx_len    <= 4'd6;
                  state     <= bcast ? S_DROP : S_TX;   // see [RQ2]
               end else begin
                  apply_idx <= apply_idx + {{(AW-1){1'b0}}, 1'b1};
                  state     <= S_RD;
               end
            end
            S_TX: begin
               // Byte stream to transmitter; it adds check and hex coding
               if (!tx_vld_out || tx_rdy_in) begin
                  if (tx_idx < tx_len) begin
                     tx_vld_out  <= 1'b1;
                     tx_byte_out <= tx_buf[tx_idx[2:0]];
                     tx_last_out <= (tx_idx + 4'd1 == tx_len);
                     tx_idx      <= tx_idx + 4'd1;
                  end else begin
                     tx_vld_out  <= 1'b0;
                     tx_last_out <= 1'b0;
                     state       <= S_DROP;
                  end
               end
            end
            S_DROP: begin
               busy_out <= 1'b0;
               state    <= S_IDLE;
            end
            default: state <= S_IDLE;
         endcase
      end
   end
endmodule // mbcmd_top
`default_nettype wire
